// ==== src/ecc_parity_lfsr.sv ====
`timescale 1ns/1ns
module ecc_parity_lfsr
    import ecc_pkg::*;
(
    input wire logic clk,                      // Core clock
    input wire logic resetn,                   // Sync reset, active low
    input wire logic clear,                    // Start of a new codeword
    input wire logic byteValid,                // Byte present on dataByte
    input wire logic [7:0] dataByte,           // Byte, bit 7 first
    output logic [PARITY_W-1:0] remainder      // Running remainder
);

    // Systematic division: data then its own parity leaves zero
    function automatic logic [PARITY_W-1:0] stepByte(
        input logic [PARITY_W-1:0] rem,
        input logic [7:0] d
    );
        logic [PARITY_W-1:0] r;
        logic fb;
        r = rem;
        for (int i = 7; i >= 0; i--)
        begin
            fb = r[PARITY_W-1] ^ d[i];
            r = {r[PARITY_W-2:0], 1'b0} ^ (fb ? PARITY_POLY : '0);
        end
        return r;
    endfunction

    always_ff @(posedge clk)
    begin
        if (!resetn || clear)
        begin
            remainder <= '0;
        end
        else if (byteValid)
        begin
            remainder <= stepByte(remainder, dataByte);
        end
    end

endmodule

// ==== src/ecc_pkg.sv ====
package ecc_pkg;

    // ------------------------------------------------------------
    // Feature table locations
    // ------------------------------------------------------------
    localparam logic [7:0] FEAT_THRESHOLD = 8'h10;
    localparam logic [7:0] FEAT_FLAGS = 8'h20;
    localparam logic [7:0] FEAT_MAX = 8'h30;
    localparam logic [7:0] FEAT_CNT_LO = 8'h40;
    localparam logic [7:0] FEAT_CNT_HI = 8'h50;
    localparam logic [7:0] FEAT_CONFIG = 8'hb0;
    localparam logic [7:0] FEAT_STATUS = 8'hc0;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_ECC_EN_BIT = 4;
    localparam int STAT_ECC_LSB = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h10;
    localparam logic [3:0] THR_RESET = 4'h4;

    // ------------------------------------------------------------
    // Serial opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_FEATURE = 8'h1f;
    localparam logic [7:0] OP_GET_FEATURE = 8'h0f;
    localparam logic [7:0] OP_READ_BUF = 8'h03;
    localparam logic [7:0] OP_READ_BUF_FAST = 8'h0b;
    localparam logic [7:0] OP_READ_BUF_X2 = 8'h3b;
    localparam logic [7:0] OP_READ_BUF_X4 = 8'h6b;

    // ------------------------------------------------------------
    // Page layout (columns)
    // ------------------------------------------------------------
    localparam logic [11:0] COL_SPARE_BASE = 12'h800;
    localparam logic [11:0] COL_PARITY_BASE = 12'h840;
    localparam logic [11:0] COL_PARITY_LAST = 12'h87f;
    localparam logic [7:0] SPARE_BYTES_ECC_ON = 8'h40;
    localparam logic [7:0] SPARE_BYTES_ECC_OFF = 8'h80;
    localparam int SECTORS = 4;

    // ------------------------------------------------------------
    // Flip codes and correction status
    // ------------------------------------------------------------
    localparam logic [3:0] FLIP_MAX_CORR = 4'h8;
    localparam logic [3:0] FLIP_UNCORR = 4'hf;
    localparam logic [3:0] FLIP_RESERVED = 4'h0;

    typedef enum logic [1:0] {
        ECC_CLEAN = 2'b00,
        ECC_CORRECTED = 2'b01,
        ECC_FAILED = 2'b10
    } ecc_status_e;

    // ------------------------------------------------------------
    // Parity code
    // ------------------------------------------------------------
    localparam int PARITY_W = 128;
    // Plain default generator; replace with the production code polynomial
    localparam logic [PARITY_W-1:0] PARITY_POLY = 128'h87;

endpackage

// ==== src/serial_nand_ecc.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Parity is built from page-buffer bytes during program busy, no host help.
// - Each 528-byte codeword detects nine and corrects eight flipped bits.
// - A codeword is one 512-byte main part plus one 16-byte spare part.
// - Sector n spans main 512n..512n+511 and spare 2048+16n..2063+16n.
// - With correction on, parity sits at 2112..2175, hidden from the host.
// - Page reads correct by themselves; status holds until the next program or read begins.
// - Correction is enabled after power-on.
// - Bit 4 at B0h switches correction on or off via Set Feature.
// - With correction off the spare area grows from 64 to 128 bytes.
// - Opcode 1Fh writes, 0Fh reads a feature, each with one address byte.
// - Correction status is bits 5:4 of location C0h.
// - Flip threshold is a four-bit setting at 10h written by Set Feature.
// - Threshold codes 1..8 are flip counts, 4 default, 15 uncorrectable.
// - Threshold flags at 20h refresh after a Read Buffer command.
// - Flags 3..0 at 20h read 1 when a sector count meets the threshold.
// - Sector flip counts sit at 40h and 50h, 0..8 or 15.
// - Location 30h holds page maximum and its lowest sector number.
module serial_nand_ecc
    import ecc_pkg::*;
(
    input wire logic clk,                      // Core clock, 125 MHz
    input wire logic resetn,                   // Sync reset, active low
    input wire logic sck,                      // Serial link clock
    input wire logic csN,                      // Chip select, active low
    input wire logic mosi,                     // Serial data in
    output logic miso,                         // Serial data out
    output logic misoOe,                       // Drive enable for miso
    input wire logic opStart,                  // Pulse: page program or read begins
    input wire logic arrayRead,                // Level: 1 read, 0 program
    input wire logic arrayValid,               // Pulse: byte on arrayByte
    input wire logic [11:0] arrayColumn,       // Column of arrayByte
    input wire logic [7:0] arrayByte,          // Page buffer byte
    input wire logic sectorDone,               // Pulse: decoder finished a sector
    input wire logic [1:0] sectorIdx,          // Sector of sectorDone
    input wire logic [3:0] decodedFlips,       // Flips fixed by decoder, 15 failed
    input wire logic operationInProgress,      // Array busy level
    input wire logic [11:0] hostColumn,        // Column the host addresses
    output logic hostColAllowed,               // Host may touch hostColumn
    input wire logic [5:0] parityColumn,       // Parity byte index 0..63
    output logic [7:0] parityByte_q,           // Parity byte for parityColumn
    output logic eccEnabled,                   // Correction active
    output logic [7:0] spareBytes              // Host-visible spare size
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Bit 2 marks a covered column, bits 1:0 the sector
    function automatic logic [2:0] sectorOf(input logic [11:0] col);
        logic [11:0] off;
        off = '0;
        if (col < COL_SPARE_BASE)
        begin
            return {1'b1, col[10:9]};
        end
        else if (col < COL_PARITY_BASE)
        begin
            off = col - COL_SPARE_BASE;
            return {1'b1, off[5:4]};
        end
        else if (col <= COL_PARITY_LAST)
        begin
            off = col - COL_PARITY_BASE;
            return {1'b1, off[5:4]};
        end
        return 3'h0;
    endfunction

    function automatic logic isReadBuffer(input logic [7:0] op);
        return op == OP_READ_BUF || op == OP_READ_BUF_FAST
            || op == OP_READ_BUF_X2 || op == OP_READ_BUF_X4;
    endfunction

    // ------------------------------------------------------------
    // Link side (sck domain)
    // ------------------------------------------------------------
    logic linkClear_q;
    logic [4:0] bitCnt_q;
    logic [6:0] shiftIn_q;
    logic [7:0] opcode_q;
    logic [7:0] addr_q;
    logic [7:0] misoSh_q;
    logic [7:0] rxByte;
    logic wrTog_q;
    logic rdTog_q;
    logic rbTog_q;
    logic [7:0] wrAddrL_q;
    logic [7:0] wrDataL_q;
    logic [7:0] rdAddrL_q;
    logic [7:0] readData_q;

    assign rxByte = {shiftIn_q, mosi};

    // Held high through core reset; clears link toggles asynchronously
    always_ff @(posedge clk)
    begin
        linkClear_q <= !resetn;
    end

    // Frame state restarts whenever select is released
    always_ff @(posedge sck or posedge csN)
    begin
        if (csN)
        begin
            bitCnt_q <= 5'h00;
            shiftIn_q <= 7'h00;
            opcode_q <= 8'h00;
            addr_q <= 8'h00;
        end
        else
        begin
            shiftIn_q <= rxByte[6:0];
            if (bitCnt_q != 5'h1f)
            begin
                bitCnt_q <= bitCnt_q + 5'h01;
            end
            if (bitCnt_q == 5'h07)
            begin
                opcode_q <= rxByte;
            end
            if (bitCnt_q == 5'h0f)
            begin
                addr_q <= rxByte;
            end
        end
    end

    // Events to the core travel as toggles with held words
    always_ff @(posedge sck or posedge linkClear_q)
    begin
        if (linkClear_q)
        begin
            wrTog_q <= 1'b0;
            rdTog_q <= 1'b0;
            rbTog_q <= 1'b0;
            wrAddrL_q <= 8'h00;
            wrDataL_q <= 8'h00;
            rdAddrL_q <= 8'h00;
        end
        else if (!csN)
        begin
            if (bitCnt_q == 5'h07 && isReadBuffer(rxByte))
            begin
                rbTog_q <= !rbTog_q;
            end
            if (bitCnt_q == 5'h0f && opcode_q == OP_GET_FEATURE)
            begin
                rdAddrL_q <= rxByte;
                rdTog_q <= !rdTog_q;
            end
            if (bitCnt_q == 5'h17 && opcode_q == OP_SET_FEATURE)
            begin
                wrAddrL_q <= addr_q;
                wrDataL_q <= rxByte;
                wrTog_q <= !wrTog_q;
            end
        end
    end

    // Answer byte loads half a link period after the request toggle;
    // the core settles readData_q within three of its cycles, far sooner
    always_ff @(negedge sck or posedge csN)
    begin
        if (csN)
        begin
            misoSh_q <= 8'h00;
        end
        else if (bitCnt_q == 5'h10)
        begin
            misoSh_q <= readData_q;
        end
        else
        begin
            misoSh_q <= {misoSh_q[6:0], 1'b0};
        end
    end

    assign miso = misoSh_q[7];
    assign misoOe = !csN && opcode_q == OP_GET_FEATURE && bitCnt_q >= 5'h10;

    // ------------------------------------------------------------
    // Crossings into the core
    // ------------------------------------------------------------
    logic [2:0] wrSync_q;
    logic [2:0] rdSync_q;
    logic [2:0] rbSync_q;
    logic wrEvent;
    logic rdEvent;
    logic rbEvent;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wrSync_q <= 3'h0;
            rdSync_q <= 3'h0;
            rbSync_q <= 3'h0;
        end
        else
        begin
            wrSync_q <= {wrSync_q[1:0], wrTog_q};
            rdSync_q <= {rdSync_q[1:0], rdTog_q};
            rbSync_q <= {rbSync_q[1:0], rbTog_q};
        end
    end

    assign wrEvent = wrSync_q[1] ^ wrSync_q[2];
    assign rdEvent = rdSync_q[1] ^ rdSync_q[2];
    assign rbEvent = rbSync_q[1] ^ rbSync_q[2];

    // ------------------------------------------------------------
    // Writable features
    // ------------------------------------------------------------
    logic [7:0] cfg_q;
    logic [3:0] thr_q;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cfg_q <= CFG_RESET;
        end
        else if (wrEvent && wrAddrL_q == FEAT_CONFIG)
        begin
            cfg_q <= wrDataL_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            thr_q <= THR_RESET;
        end
        // reserved codes leave the setting unchanged
        else if (wrEvent && wrAddrL_q == FEAT_THRESHOLD && wrDataL_q[3:0] != FLIP_RESERVED
            && (wrDataL_q[3:0] <= FLIP_MAX_CORR || wrDataL_q[3:0] == FLIP_UNCORR))
        begin
            thr_q <= wrDataL_q[3:0];
        end
    end

    assign eccEnabled = cfg_q[CFG_ECC_EN_BIT];
    assign spareBytes = eccEnabled ? SPARE_BYTES_ECC_ON : SPARE_BYTES_ECC_OFF;

    assign hostColAllowed = !(eccEnabled && hostColumn >= COL_PARITY_BASE
        && hostColumn <= COL_PARITY_LAST);

    // ------------------------------------------------------------
    // Parity engines, one per sector
    // ------------------------------------------------------------
    logic [2:0] colSector;
    logic colIsParity;
    logic [PARITY_W-1:0] remainder [SECTORS];

    assign colSector = sectorOf(arrayColumn);
    assign colIsParity = arrayColumn >= COL_PARITY_BASE;

    for (genvar s = 0; s < SECTORS; s++)
    begin : g_sector
        logic feed;
        // program feeds data, columns steer to sector
        assign feed = arrayValid && eccEnabled && colSector[2]
            && colSector[1:0] == 2'(s) && (arrayRead || !colIsParity);
        // one engine spans main and spare part
        ecc_parity_lfsr u_lfsr (
            .clk(clk),
            .resetn(resetn),
            .clear(opStart),
            .byteValid(feed),
            .dataByte(arrayByte),
            .remainder(remainder[s])
        );
    end

    // First parity byte of a sector is the remainder's top byte
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            parityByte_q <= 8'h00;
        end
        else
        begin
            parityByte_q <= remainder[parityColumn[5:4]][8'(PARITY_W - 1
                - 8 * int'(parityColumn[3:0])) -: 8];
        end
    end

    // ------------------------------------------------------------
    // Read results
    // ------------------------------------------------------------
    logic [3:0] flipCnt_q [SECTORS];
    logic [3:0] flags_q;
    logic [3:0] recordCode;
    logic [3:0] maxCnt;
    logic [1:0] maxSector;
    ecc_status_e status;

    // nonzero syndrome with no flips reported, or more than eight flips
    always_comb
    begin
        recordCode = decodedFlips;
        if (decodedFlips > FLIP_MAX_CORR)
        begin
            recordCode = FLIP_UNCORR;
        end
        else if (decodedFlips == 4'h0 && remainder[sectorIdx] != '0)
        begin
            recordCode = FLIP_UNCORR;
        end
    end

    always_ff @(posedge clk)
    begin
        for (int s = 0; s < SECTORS; s++)
        begin
            if (!resetn)
            begin
                flipCnt_q[s] <= 4'h0;
            end
            else if (sectorDone && eccEnabled && sectorIdx == 2'(s))
            begin
                flipCnt_q[s] <= recordCode;
            end
            // cleared on reset or when a new operation begins
            else if (opStart)
            begin
                flipCnt_q[s] <= 4'h0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            flags_q <= 4'h0;
        end
        else if (rbEvent)
        begin
            for (int s = 0; s < SECTORS; s++)
            begin
                flags_q[s] <= eccEnabled && flipCnt_q[s] >= thr_q;
            end
        end
        // Refresh wins over a new operation in the same cycle
        else if (opStart)
        begin
            flags_q <= 4'h0;
        end
    end

    // descending scan keeps the lowest sector on a tie
    always_comb
    begin
        maxCnt = flipCnt_q[SECTORS-1];
        maxSector = 2'(SECTORS - 1);
        for (int s = SECTORS - 2; s >= 0; s--)
        begin
            if (flipCnt_q[s] >= maxCnt)
            begin
                maxCnt = flipCnt_q[s];
                maxSector = 2'(s);
            end
        end
    end

    always_comb
    begin
        status = ECC_CLEAN;
        for (int s = 0; s < SECTORS; s++)
        begin
            if (flipCnt_q[s] == FLIP_UNCORR)
            begin
                status = ECC_FAILED;
            end
            else if (flipCnt_q[s] != 4'h0 && status == ECC_CLEAN)
            begin
                status = ECC_CORRECTED;
            end
        end
    end

    // ------------------------------------------------------------
    // Feature readback
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            readData_q <= 8'h00;
        end
        else if (rdEvent)
        begin
            case (rdAddrL_q)
                FEAT_THRESHOLD: readData_q <= {4'h0, thr_q};
                FEAT_FLAGS: readData_q <= {4'h0, flags_q};
                FEAT_MAX: readData_q <= {maxCnt, 2'b00, maxSector};
                FEAT_CNT_LO: readData_q <= {flipCnt_q[1], flipCnt_q[0]};
                FEAT_CNT_HI: readData_q <= {flipCnt_q[3], flipCnt_q[2]};
                FEAT_CONFIG: readData_q <= cfg_q;
                FEAT_STATUS:
                begin
                    readData_q <= 8'h00;
                    readData_q[STAT_ECC_LSB +: 2] <= status;
                    readData_q[STAT_BUSY_BIT] <= operationInProgress;
                end
                default: readData_q <= 8'h00;
            endcase
        end
    end

endmodule

// ==== verification/serial_nand_ecc_chk.sv ====
`timescale 1ns/1ns
module serial_nand_ecc_chk
    import ecc_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic resetn, // Sync reset
    input wire logic csN, // Chip select
    input wire logic misoOe, // Drive enable
    input wire logic [11:0] hostColumn, // Host column
    input wire logic hostColAllowed, // Column open
    input wire logic [7:0] parityByte_q, // Parity byte
    input wire logic eccEnabled, // Correction on
    input wire logic [7:0] spareBytes // Spare size
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic [3:0] idleCnt_q;
    wire inParity = hostColumn >= COL_PARITY_BASE && hostColumn <= COL_PARITY_LAST;
    // Writes land a few clocks late, so only quiet time counts
    always_ff @(posedge clk)
    begin
        if (!resetn || !csN)
            idleCnt_q <= 4'h0;
        else if (idleCnt_q != 4'hf)
            idleCnt_q <= idleCnt_q + 4'h1;
    end
    sequence frameOpen;
        $fell(csN);
    endsequence
    a_parity_hidden: assert property (eccEnabled && inParity |-> !hostColAllowed)
        else $error("parity column open");
    a_column_open: assert property (!(eccEnabled && inParity) |-> hostColAllowed)
        else $error("column blocked");
    a_spare_on: assert property (eccEnabled |-> spareBytes == SPARE_BYTES_ECC_ON)
        else $error("spare size on");
    a_spare_off: assert property (!eccEnabled |-> spareBytes == SPARE_BYTES_ECC_OFF)
        else $error("spare size off");
    a_reset_default: assert property ($rose(resetn) |-> eccEnabled && !parityByte_q)
        else $error("reset defaults");
    a_oe_deselect: assert property (csN |-> !misoOe)
        else $error("miso driven unselected");
    a_oe_frame: assert property (frameOpen |-> !misoOe [*8])
        else $error("miso driven early");
    a_enable_quiet: assert property (idleCnt_q >= 4'h8 |-> $stable(eccEnabled))
        else $error("enable moved without command");
endmodule

bind serial_nand_ecc serial_nand_ecc_chk u_chk (.clk(clk), .resetn(resetn), .csN(csN),
    .misoOe(misoOe), .hostColumn(hostColumn), .hostColAllowed(hostColAllowed),
    .parityByte_q(parityByte_q), .eccEnabled(eccEnabled), .spareBytes(spareBytes));

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ns
module spi_host_model (
    output logic sck, // Link clock, still outside frames
    output logic csN, // Chip select, active low
    output logic mosi, // Data to device
    input wire logic miso, // Data from device
    input wire logic misoOe // Device drives miso
);
    initial
    begin
        sck = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] rd);
        logic [23:0] sh;
        sh = {op, a, d};
        rd = 8'h00;
        // Keep link edges off the core clock edges
        #(10 - ($time % 8));
        csN = 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            mosi = sh[23 - i];
            #40;
            sck = 1'b1;
            if (i >= 16)
                rd = {rd[6:0], misoOe ? miso : 1'bx};
            #80;
            sck = 1'b0;
            #40;
        end
        csN = 1'b1;
        mosi = ~mosi;
        #200;
    endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
    import ecc_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic opStart = 1'b0;
    logic arrayRead = 1'b0;
    logic arrayValid = 1'b0;
    logic sectorDone = 1'b0;
    logic operation_in_progress = 1'b0;
    logic [11:0] arrayColumn = 12'h000;
    logic [11:0] hostColumn = 12'h000;
    logic [7:0] arrayByte = 8'h00;
    logic [1:0] sectorIdx = 2'h0;
    logic [3:0] decodedFlips = 4'h0;
    logic [5:0] parityColumn = 6'h00;
    logic sck, csN, mosi, miso, misoOe, hostColAllowed, eccEnabled, en;
    logic [7:0] parityByte_q, spareBytes, rd;
    logic [31:0] seed = 32'h10604e74;
    logic [7:0] page [0:2175];
    logic [3:0] thr, mx, fg;
    logic [3:0] fl [4];
    logic [3:0] rep [4];
    logic [1:0] ms, st, bad;
    logic [PARITY_W-1:0] par;
    logic [11:0] corner [4] = '{12'h83f, 12'h840, 12'h87f, 12'h880};
    int err_total = 0;
    int n_tests = 0;

    spi_host_model HOST (.sck(sck), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe));
    serial_nand_ecc DUT (.clk(clk), .resetn(resetn), .sck(sck), .csN(csN), .mosi(mosi),
        .miso(miso), .misoOe(misoOe), .opStart(opStart), .arrayRead(arrayRead),
        .arrayValid(arrayValid), .arrayColumn(arrayColumn), .arrayByte(arrayByte),
        .sectorDone(sectorDone), .sectorIdx(sectorIdx), .decodedFlips(decodedFlips),
        .operationInProgress(operation_in_progress), .hostColumn(hostColumn), .hostColAllowed(hostColAllowed),
        .parityColumn(parityColumn), .parityByte_q(parityByte_q), .eccEnabled(eccEnabled),
        .spareBytes(spareBytes));

    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Byte j of sector s: main, then spare, then parity
    function automatic logic [11:0] col(input int s, input int j);
        if (j < 512)
            return 12'(512 * s + j);
        return 12'(j < 528 ? 1536 + 16 * s + j : 1584 + 16 * s + j);
    endfunction
    function automatic logic [PARITY_W-1:0] crc8(input logic [PARITY_W-1:0] r,
        input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            r = (r << 1) ^ ((r[PARITY_W-1] ^ d[i]) ? PARITY_POLY : '0);
        return r;
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask
    task automatic getf(input logic [7:0] a, input logic [7:0] exp, input string name);
        HOST.xfer(OP_GET_FEATURE, a, 8'h00, rd);
        chk(name, exp, rd);
    endtask
    task automatic setf(input logic [7:0] a, input logic [7:0] d);
        HOST.xfer(OP_SET_FEATURE, a, d, rd);
    endtask
    task automatic run_op(input logic isRead);
        @(posedge clk);
        opStart <= 1'b1;
        arrayRead <= isRead;
        operation_in_progress <= 1'b1;
        @(posedge clk);
        opStart <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            for (int j = 0; j < (isRead ? 544 : 528); j++)
            begin
                arrayValid <= 1'b1;
                arrayColumn <= col(s, j);
                arrayByte <= page[col(s, j)];
                @(posedge clk);
            end
            arrayValid <= 1'b0;
            repeat (2) @(posedge clk);
            sectorDone <= isRead;
            sectorIdx <= 2'(s);
            decodedFlips <= fl[s];
            @(posedge clk);
            sectorDone <= 1'b0;
        end
        operation_in_progress <= 1'b0;
        @(posedge clk);
    endtask
    task automatic complete_run();
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #700000;
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        getf(FEAT_CONFIG, CFG_RESET, "config");
        getf(FEAT_STATUS, 8'h00, "status");
        getf(FEAT_FLAGS, 8'h00, "flags");
        thr = THR_RESET;
        for (int c = 0; c < 16; c++)
        begin
            getf(FEAT_THRESHOLD, {4'h0, thr}, "threshold");
            setf(FEAT_THRESHOLD, 8'(c));
            if ((c >= 1 && c <= 8) || c == 15)
                thr = 4'(c);
        end
        for (int i = 0; i < 2112; i++)
        begin
            seed = xs(seed);
            page[i] = seed[7:0];
        end
        for (int s = 0; s < 4; s++)
        begin
            par = '0;
            for (int j = 0; j < 528; j++)
                par = crc8(par, page[col(s, j)]);
            for (int k = 0; k < 16; k++)
                page[2112 + 16 * s + k] = par[127 - 8 * k -: 8];
        end
        run_op(1'b0);
        for (int k = 0; k < 64; k++)
        begin
            parityColumn <= 6'(k);
            repeat (2) @(posedge clk);
            chk("parity", page[2112 + k], parityByte_q);
        end
        for (int it = 0; it < 4; it++)
        begin
            en = (it != 1);
            seed = xs(seed);
            thr = 4'(seed % 8) + 4'h1;
            bad = seed[9:8];
            setf(FEAT_THRESHOLD, {4'h0, thr});
            setf(FEAT_CONFIG, en ? CFG_RESET : 8'h00);
            chk("enable", {7'h0, en}, {7'h0, eccEnabled});
            chk("spare", en ? SPARE_BYTES_ECC_ON : SPARE_BYTES_ECC_OFF, spareBytes);
            for (int k = 0; k < 8; k++)
            begin
                seed = xs(seed);
                @(posedge clk);
                hostColumn <= k < 4 ? corner[k] : seed[11:0];
                @(posedge clk);
                chk("column", {7'h0, !(en && hostColumn >= COL_PARITY_BASE
                    && hostColumn <= COL_PARITY_LAST)}, {7'h0, hostColAllowed});
            end
            mx = 4'h0;
            ms = 2'h0;
            fg = 4'h0;
            for (int s = 0; s < 4; s++)
            begin
                seed = xs(seed);
                fl[s] = (it == 3 || (it == 0 && s == bad)) ? 4'h0 : s == 1 ? thr : 4'(seed % 9);
                rep[s] = !en ? 4'h0 : (it == 0 && s == bad) ? FLIP_UNCORR : fl[s];
                if (rep[s] > mx)
                begin
                    mx = rep[s];
                    ms = 2'(s);
                end
                fg[s] = en && rep[s] >= thr;
            end
            st = mx == FLIP_UNCORR ? ECC_FAILED : mx != 4'h0 ? ECC_CORRECTED : ECC_CLEAN;
            page[col(bad, 7)] ^= (it == 0) ? 8'h10 : 8'h00;
            run_op(1'b1);
            page[col(bad, 7)] ^= (it == 0) ? 8'h10 : 8'h00;
            @(posedge clk);
            operation_in_progress <= seed[12];
            getf(FEAT_STATUS, {2'b00, st, 3'b000, seed[12]}, "status");
            getf(FEAT_CNT_LO, {rep[1], rep[0]}, "count lo");
            getf(FEAT_CNT_HI, {rep[3], rep[2]}, "count hi");
            getf(FEAT_MAX, {mx, 2'b00, ms}, "max");
            getf(FEAT_FLAGS, 8'h00, "flags early");
            HOST.xfer(OP_READ_BUF, 8'h00, 8'h00, rd);
            getf(FEAT_FLAGS, {4'h0, fg}, "flags");
            setf(FEAT_FLAGS, 8'hff);
            getf(FEAT_FLAGS, {4'h0, fg}, "flags ro");
        end
        complete_run();
    end
endmodule
